// ==== core/irqa_ack.sv ====
// Interrupt acknowledge and nesting unit of an 8-bit CPU core.
// Assumes peripheral events and sequencer strobes are on aclk, and
// that the sequencer honours cpu_stall while an entry sequence runs.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps

module irqa_ack (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address and data
  input  wire logic [irqa_pkg::IRQA_AW-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [irqa_pkg::IRQA_AW-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Peripheral request events
  input  wire logic [irqa_pkg::IRQA_NSRC-1:0] src_event,
  // Instruction sequencer strobes
  input  wire logic                         instr_done,
  input  wire logic                         instr_holds,
  input  wire logic                         div_busy,
  input  wire logic                         soft_trap_instr,
  input  wire logic                         return_from_irq,
  input  wire logic                         return_from_trap,
  input  wire logic                         unmask_all_instr,
  input  wire logic                         mask_all_instr,
  input  wire logic [7:0]                   popped_status,
  // Entry sequence towards the sequencer
  output logic                              cpu_stall,
  output logic                              push_status_stb,
  output logic                              push_pc_stb,
  output logic [7:0]                        push_data,
  output logic                              branch_stb,
  output logic [15:0]                       branch_addr,
  output logic [irqa_pkg::IRQA_SW-1:0]      ack_source,
  output logic [7:0]                        status_word
);
  import irqa_pkg::*;

  // Lowest set bit wins: the fixed default order
  function automatic logic [IRQA_SW-1:0] pick_first(
    input logic [IRQA_NSRC-1:0] vec
  );
    logic [IRQA_SW-1:0] idx;
    idx = '0;
    for (int i = IRQA_NSRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = IRQA_SW'(i);
      end
    end
    return idx;
  endfunction

  // Vector slot of a maskable source
  function automatic logic [15:0] vec_of(input logic [IRQA_SW-1:0] src);
    logic [15:0] step;
    step = IRQA_VEC_STEP * {13'h0000, src};
    return IRQA_VEC_BASE + step;
  endfunction

  logic [IRQA_NSRC-1:0] req_reg;
  logic [IRQA_NSRC-1:0] mask_reg;
  logic [IRQA_NSRC-1:0] level_reg;
  logic [7:0]           status_word_reg;
  logic                 in_trap_reg;
  logic                 hold_reg;
  logic                 lo_ripe_reg;
  irqa_seq_e            seq_reg;
  irqa_seq_e            seq_next;
  logic [7:0]           push_data_reg;
  logic [15:0]          branch_addr_reg;
  logic [IRQA_SW-1:0]   ack_source_reg;

  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [IRQA_AW-1:0]   awaddr_reg;
  logic [7:0]           wdata_reg;
  logic                 wlane_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [31:0]          rdata_reg;
  logic [1:0]           rresp_reg;

  logic                 do_write;
  logic                 wr_req;
  logic                 wr_mask;
  logic                 wr_level;
  logic                 wr_status;
  logic                 wr_mapped;

  logic [IRQA_NSRC-1:0] eligible;
  logic [IRQA_NSRC-1:0] hi_vec;
  logic [IRQA_NSRC-1:0] lo_vec;
  logic                 accept_flag;
  logic                 low_allowed;
  logic                 boundary_ok;
  logic                 take_hi;
  logic                 take_lo;
  logic                 take_mask;
  logic                 take_trap;
  logic [IRQA_SW-1:0]   take_src;
  logic [IRQA_NSRC-1:0] ack_clr;

  // Bus write decode
  assign do_write  = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_req    = do_write & wlane_reg & (awaddr_reg == IRQA_OFS_REQ);
  assign wr_mask   = do_write & wlane_reg & (awaddr_reg == IRQA_OFS_MASK);
  assign wr_level  = do_write & wlane_reg & (awaddr_reg == IRQA_OFS_LEVEL);
  assign wr_status = do_write & wlane_reg
                   & (awaddr_reg == IRQA_OFS_STATUS);
  assign wr_mapped = (awaddr_reg == IRQA_OFS_REQ)
                   | (awaddr_reg == IRQA_OFS_MASK)
                   | (awaddr_reg == IRQA_OFS_LEVEL)
                   | (awaddr_reg == IRQA_OFS_STATUS)
                   | (awaddr_reg == IRQA_OFS_SERVICE);

  // Qualification and arbitration
  assign eligible    = req_reg & ~mask_reg;
  assign hi_vec      = eligible & ~level_reg;
  assign lo_vec      = eligible & level_reg;
  assign accept_flag = status_word_reg[IRQA_ACCEPT_BIT];
  // Trap service lets both levels nest, whatever the nest flag says
  assign low_allowed = status_word_reg[IRQA_NEST_BIT]
                     | in_trap_reg;
  // Only at an instruction boundary; a divide never ends early
  assign boundary_ok = instr_done & ~div_busy & ~hold_reg
                     & ~instr_holds & (seq_reg == IRQA_IDLE);
  assign take_trap   = soft_trap_instr
                     & (seq_reg == IRQA_IDLE);
  // A trap in the same cycle wins and clears the accept flag
  assign take_hi     = boundary_ok & ~take_trap & accept_flag
                     & (|hi_vec);
  // Low level waits one more clock, giving the longer latency
  assign take_lo     = boundary_ok & ~take_trap & accept_flag & ~(|hi_vec)
                     & (|lo_vec) & lo_ripe_reg & low_allowed;
  assign take_mask   = take_hi | take_lo;
  assign take_src    = take_hi ? pick_first(hi_vec)
                               : pick_first(lo_vec);

  generate
    for (genvar g = 0; g < IRQA_NSRC; g++) begin : g_clr
      assign ack_clr[g] = take_mask & (take_src == IRQA_SW'(g));
    end
  endgenerate

  // Pending flags: an event beats any clear in the same cycle
  generate
    for (genvar g = 0; g < IRQA_NSRC; g++) begin : g_req
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          req_reg[g] <= IRQA_RST_REQ[g];
        end else if (src_event[g]) begin
          req_reg[g] <= 1'b1;
        end else if (wr_req) begin
          req_reg[g] <= wdata_reg[g];
        end else if (ack_clr[g]) begin
          req_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= IRQA_RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= wdata_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= IRQA_RST_LEVEL;
    end else if (wr_level) begin
      level_reg <= wdata_reg;
    end
  end

  // Status word: entry, restore, unmask/mask, then software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_word_reg <= IRQA_RST_STATUS;
    end else if (take_trap) begin
      status_word_reg[IRQA_ACCEPT_BIT] <= 1'b0;
    end else if (take_mask) begin
      status_word_reg[IRQA_ACCEPT_BIT] <= 1'b0;
      status_word_reg[IRQA_NEST_BIT]   <= level_reg[take_src];
    end else if (return_from_irq | return_from_trap) begin
      status_word_reg <= popped_status;
    end else if (unmask_all_instr) begin
      status_word_reg[IRQA_ACCEPT_BIT] <= 1'b1;
    end else if (mask_all_instr) begin
      status_word_reg[IRQA_ACCEPT_BIT] <= 1'b0;
    end else if (wr_status) begin
      status_word_reg <= wdata_reg;
    end
  end

  // Trap service marker for the nesting decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_trap_reg <= 1'b0;
    end else if (take_trap) begin
      in_trap_reg <= 1'b1;
    end else if (return_from_trap) begin
      in_trap_reg <= 1'b0;
    end
  end

  // Deferral: ends with the next completed instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 1'b0;
    end else if (return_from_irq | return_from_trap
                 | unmask_all_instr | mask_all_instr
                 | wr_req | wr_mask | wr_level | wr_status
                 | (instr_done & instr_holds)) begin
      hold_reg <= 1'b1;
    end else if (instr_done) begin
      hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_ripe_reg <= 1'b0;
    end else begin
      lo_ripe_reg <= |lo_vec;
    end
  end

  // Entry sequence: status push, PC push, branch
  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      IRQA_IDLE: begin
        if (take_trap | take_mask) begin
          seq_next = IRQA_PUSH_SW;
        end
      end
      IRQA_PUSH_SW: begin
        seq_next = IRQA_PUSH_PC;
      end
      IRQA_PUSH_PC: begin
        seq_next = IRQA_BRANCH;
      end
      IRQA_BRANCH: begin
        seq_next = IRQA_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= IRQA_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Entry data captured before the status word changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      push_data_reg   <= IRQA_RST_STATUS;
      branch_addr_reg <= IRQA_TRAP_VEC;
      ack_source_reg  <= '0;
    end else if (take_trap) begin
      push_data_reg   <= status_word_reg;
      branch_addr_reg <= IRQA_TRAP_VEC;
    end else if (take_mask) begin
      push_data_reg   <= status_word_reg;
      branch_addr_reg <= vec_of(take_src);
      ack_source_reg  <= take_src;
    end
  end

  assign cpu_stall       = (seq_reg != IRQA_IDLE);
  assign push_status_stb = (seq_reg == IRQA_PUSH_SW);
  assign push_pc_stb     = (seq_reg == IRQA_PUSH_PC);
  assign branch_stb      = (seq_reg == IRQA_BRANCH);
  assign push_data       = push_data_reg;
  assign branch_addr     = branch_addr_reg;
  assign ack_source      = ack_source_reg;
  assign status_word     = status_word_reg;

  // AXI write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid & ~aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wlane_reg  <= 1'b0;
    end else if (s_axi_wvalid & ~w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata[7:0];
      wlane_reg  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= IRQA_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? IRQA_RESP_OKAY : IRQA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // AXI read; service register is read-only state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= IRQA_RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= IRQA_RESP_OKAY;
      rdata_reg  <= '0;
      unique case (s_axi_araddr)
        IRQA_OFS_REQ:    rdata_reg[7:0] <= req_reg;
        IRQA_OFS_MASK:   rdata_reg[7:0] <= mask_reg;
        IRQA_OFS_LEVEL:  rdata_reg[7:0] <= level_reg;
        IRQA_OFS_STATUS: rdata_reg[7:0] <= status_word_reg;
        IRQA_OFS_SERVICE: begin
          rdata_reg[IRQA_SVC_TRAP]  <= in_trap_reg;
          rdata_reg[IRQA_SVC_BUSY]  <= cpu_stall;
          rdata_reg[IRQA_SW-1:0]    <= ack_source_reg;
        end
        default:         rresp_reg <= IRQA_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

endmodule

// ==== inc/irqa_pkg.sv ====
// Package for the interrupt acknowledge unit: register map, reset
// values, flag positions, vectors and sequencer states.
// Assumes a 100 MHz CPU clock and a 32-bit AXI4-Lite register bus.
package irqa_pkg;

  // Source count and bus address width
  localparam int IRQA_NSRC = 8;
  localparam int IRQA_SW   = 3;
  localparam int IRQA_AW   = 5;

  // Register byte offsets
  localparam logic [IRQA_AW-1:0] IRQA_OFS_REQ     = 5'h00;
  localparam logic [IRQA_AW-1:0] IRQA_OFS_MASK    = 5'h04;
  localparam logic [IRQA_AW-1:0] IRQA_OFS_LEVEL   = 5'h08;
  localparam logic [IRQA_AW-1:0] IRQA_OFS_STATUS  = 5'h0C;
  localparam logic [IRQA_AW-1:0] IRQA_OFS_SERVICE = 5'h10;

  // Reset values
  localparam logic [7:0] IRQA_RST_REQ    = 8'h00;
  localparam logic [7:0] IRQA_RST_MASK   = 8'hFF;
  localparam logic [7:0] IRQA_RST_LEVEL  = 8'hFF;
  localparam logic [7:0] IRQA_RST_STATUS = 8'h02;

  // Field positions in the status word and service register
  localparam int IRQA_ACCEPT_BIT = 7;
  localparam int IRQA_NEST_BIT   = 1;
  localparam int IRQA_SVC_TRAP   = 7;
  localparam int IRQA_SVC_BUSY   = 6;

  // Vector table addresses
  localparam logic [15:0] IRQA_TRAP_VEC = 16'h003E;
  localparam logic [15:0] IRQA_VEC_BASE = 16'h0004;
  localparam logic [15:0] IRQA_VEC_STEP = 16'h0002;

  // Latency figures in CPU clocks, request to vectored servicing
  localparam int IRQA_LAT_HI_MIN_CLK = 7;
  localparam int IRQA_LAT_HI_MAX_CLK = 32;
  localparam int IRQA_LAT_LO_MIN_CLK = 8;
  localparam int IRQA_LAT_LO_MAX_CLK = 33;

  // Bus responses
  localparam logic [1:0] IRQA_RESP_OKAY   = 2'b00;
  localparam logic [1:0] IRQA_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    IRQA_IDLE,
    IRQA_PUSH_SW,
    IRQA_PUSH_PC,
    IRQA_BRANCH
  } irqa_seq_e;

endpackage

// ==== tb/irqa_ack_chk.sv ====
// Checker for the acknowledge unit, bound to every irqa_ack instance.
// Assumes one aclk domain and sees only the unit's own ports.
`timescale 1ns/100ps
module irqa_ack_chk (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Sequencer strobes
  input wire logic                    instr_done,
  input wire logic                    instr_holds,
  input wire logic                    div_busy,
  input wire logic                    soft_trap_instr,
  input wire logic                    return_from_irq,
  input wire logic                    return_from_trap,
  input wire logic                    unmask_all_instr,
  input wire logic [7:0]              popped_status,
  // Entry sequence
  input wire logic                    cpu_stall,
  input wire logic                    push_status_stb,
  input wire logic                    push_pc_stb,
  input wire logic [7:0]              push_data,
  input wire logic                    branch_stb,
  input wire logic [15:0]             branch_addr,
  input wire logic [irqa_pkg::IRQA_SW-1:0] ack_source,
  input wire logic [7:0]              status_word
);
  import irqa_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire trap_go = soft_trap_instr && !cpu_stall;

  a_trap_vector: assert property (trap_go |=> push_status_stb
    ##1 push_pc_stb ##1 (branch_stb && branch_addr == IRQA_TRAP_VEC))
    else $error("trap entry sequence wrong");
  a_trap_clear: assert property (trap_go |=> !status_word[7])
    else $error("trap left accept set");
  a_stall_len: assert property ($rose(cpu_stall) |->
    cpu_stall[*3] ##1 !cpu_stall) else $error("stall length wrong");
  a_accept_off: assert property (instr_done && !status_word[7]
    && !trap_go |=> !push_status_stb) else $error("entry while disabled");
  a_div_wait: assert property (instr_done && div_busy && !trap_go
    |=> !push_status_stb) else $error("entry during divide");
  a_hold_wait: assert property (instr_done && instr_holds
    && !trap_go |=> !push_status_stb) else $error("entry after hold");
  a_push_word: assert property (push_status_stb |->
    push_data == $past(status_word) && !status_word[IRQA_ACCEPT_BIT])
    else $error("pushed status wrong");
  a_mask_vec: assert property (push_status_stb &&
    !$past(soft_trap_instr) |-> ##2 branch_stb &&
    branch_addr == IRQA_VEC_BASE + 16'(ack_source) * IRQA_VEC_STEP)
    else $error("maskable vector wrong");
  a_irq_return: assert property (return_from_irq && !instr_done
    && !trap_go |=> status_word == $past(popped_status))
    else $error("status not restored");
  a_unmask_set: assert property (unmask_all_instr && !instr_done
    && !trap_go && !return_from_irq && !return_from_trap
    |=> status_word[IRQA_ACCEPT_BIT]) else $error("accept not set");
  a_ret_defer: assert property (return_from_irq |->
    ##2 !push_status_stb) else $error("entry right after return");

  c_trap: cover property (trap_go);
  c_mask_entry: cover property (push_status_stb && !$past(soft_trap_instr));
  c_low_nest: cover property (push_status_stb && status_word[1]);
endmodule

bind irqa_ack irqa_ack_chk u_chk (.aclk, .aresetn, .instr_done,
  .instr_holds, .div_busy, .soft_trap_instr, .return_from_irq,
  .return_from_trap, .unmask_all_instr, .popped_status, .cpu_stall,
  .push_status_stb, .push_pc_stb, .push_data, .branch_stb, .branch_addr,
  .ack_source, .status_word);

// ==== tb/irqa_seq_model.sv ====
// Sequencer partner: paces instruction boundaries and keeps a stack
// of pushed status words. Assumes the unit's aclk domain.
`timescale 1ns/100ps
module irqa_seq_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Cycles between boundaries, 1 to 15
  input  wire logic [3:0] gap,
  // From the unit and the program
  input  wire logic       cpu_stall,
  input  wire logic       push_status_stb,
  input  wire logic [7:0] push_data,
  input  wire logic       ret,
  // Towards the unit
  output logic            instr_done,
  output logic [7:0]      popped_status
);
  logic [3:0] cnt;
  logic [7:0] stk [8];
  int         sp;

  // No boundary while the entry sequence owns the core
  assign instr_done = aresetn && !cpu_stall && cnt == gap - 4'h1;
  assign popped_status = sp > 0 ? stk[sp-1] : 8'hFD;

  always @(posedge aclk) begin
    if (!aresetn || cnt >= gap - 4'h1) cnt <= 4'h0;
    else if (!cpu_stall) cnt <= cnt + 4'h1;
  end

  always @(posedge aclk) begin
    if (!aresetn) sp <= 0;
    else if (push_status_stb) begin
      stk[sp] <= push_data;
      sp <= sp + 1;
    end else if (ret && sp > 0) sp <= sp - 1;
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for irqa_ack with the paced sequencer partner.
// Assumes the package map and the hand-over timing of the unit.
`timescale 1ns/100ps
module tb_top;
  import irqa_pkg::*;
  logic        aclk = 0, aresetn = 0, instr_done, cpu_stall;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0, op = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h000143A6;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  src_event = 0, popped_status, push_data, status_word;
  logic        instr_holds = 0, div_busy = 0;
  logic        push_status_stb, push_pc_stb, branch_stb;
  logic [15:0] branch_addr;
  logic [2:0]  ack_source;
  logic [3:0]  gap = 4'h3;
  logic [7:0]  rv [6] = '{IRQA_RST_REQ, IRQA_RST_MASK, IRQA_RST_LEVEL,
                          IRQA_RST_STATUS, 8'h00, 8'h00};
  int          n_fail = 0, checks_done = 0;

  always #5 aclk = ~aclk;

  irqa_ack u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_event, .instr_done,
    .instr_holds, .div_busy, .soft_trap_instr(op[0]),
    .return_from_irq(op[1]), .return_from_trap(op[2]),
    .unmask_all_instr(op[3]), .mask_all_instr(op[4]), .popped_status,
    .cpu_stall, .push_status_stb, .push_pc_stb, .push_data, .branch_stb,
    .branch_addr, .ack_source, .status_word);

  irqa_seq_model u_seq (.aclk, .aresetn, .gap, .cpu_stall, .push_status_stb,
    .push_data, .ret(op[1] | op[2]), .instr_done, .popped_status);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reference pick: high level first, then lowest index
  function automatic int pick(logic [7:0] e, logic [7:0] l);
    for (int i = 0; i < 8; i++) if (e[i] && !l[i]) return i;
    for (int i = 0; i < 8; i++) if (e[i]) return i;
    return 0;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] ev,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, ev});
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    op[k] <= 1'b1;
    @(posedge aclk);
    op[k] <= 1'b0;
  endtask

  task automatic fire(input logic [7:0] e);
    @(posedge aclk);
    src_event <= e;
    @(posedge aclk);
    src_event <= 8'h00;
  endtask

  // Counts edges until the first push strobe is seen
  task automatic entry(output int t);
    t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (push_status_stb !== 1'b1);
  endtask

  task automatic quiet(input int n);
    int s;
    s = 0;
    repeat (n) begin
      @(posedge aclk);
      if (push_status_stb === 1'b1) s++;
    end
    chk(32'(s), 32'h0);
  endtask

  task automatic vec(input logic [15:0] a);
    repeat (2) @(posedge aclk);
    chk(32'(branch_stb), 32'h1);
    chk(32'(branch_addr), 32'(a));
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  initial begin
    int t, s;
    logic [31:0] r;
    logic [7:0]  msk, lvl, ev, el;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(status_word), 32'h02);
    for (int i = 0; i < 6; i++)
      rd(5'(4 * i), rv[i], i == 5 ? IRQA_RESP_SLVERR : IRQA_RESP_OKAY);
    wr(5'h14, 8'h55, IRQA_RESP_SLVERR);
    wr(IRQA_OFS_MASK, 8'hFB, IRQA_RESP_OKAY);
    fire(8'h04);
    quiet(16);
    pulse(0);
    entry(t);
    chk(32'(status_word), 32'h02);
    vec(IRQA_TRAP_VEC);
    rd(IRQA_OFS_SERVICE, 8'h80, IRQA_RESP_OKAY);
    quiet(16);
    pulse(3);
    entry(t);
    chk(32'(ack_source), 32'h2);
    chk(32'(push_data), 32'h82);
    vec(16'h0008);
    pulse(1);
    @(posedge aclk);
    chk(32'(status_word), 32'h82);
    pulse(2);
    @(posedge aclk);
    chk(32'(status_word), 32'h02);
    for (int it = 0; it < 6; it++) begin
      r = rnd();
      {ev, lvl, msk} = r[23:0];
      gap <= 4'(r[26:24]) + 4'h1;
      pulse(4);
      wr(IRQA_OFS_REQ, 8'h00, IRQA_RESP_OKAY);
      wr(IRQA_OFS_MASK, msk, IRQA_RESP_OKAY);
      wr(IRQA_OFS_LEVEL, lvl, IRQA_RESP_OKAY);
      fire(ev);
      quiet(12);
      rd(IRQA_OFS_REQ, ev, IRQA_RESP_OKAY);
      pulse(3);
      for (el = ev & ~msk; el != 8'h00; el[s] = 1'b0) begin
        s = pick(el, lvl);
        entry(t);
        chk(32'(ack_source), 32'(s));
        chk(32'(status_word), {30'h0, lvl[s], 1'b0});
        vec(IRQA_VEC_BASE + 16'(s) * IRQA_VEC_STEP);
        pulse(1);
        @(posedge aclk);
        chk(32'(status_word), 32'h82);
      end
    end
    pulse(4);
    wr(IRQA_OFS_REQ, 8'h00, IRQA_RESP_OKAY);
    wr(IRQA_OFS_MASK, 8'h00, IRQA_RESP_OKAY);
    wr(IRQA_OFS_LEVEL, 8'hFC, IRQA_RESP_OKAY);
    pulse(3);
    quiet(20);
    fire(8'h01);
    entry(t);
    chk(32'(t <= IRQA_LAT_HI_MAX_CLK), 32'h1);
    chk(32'(status_word), 32'h00);
    pulse(3);
    fire(8'h08);
    quiet(20);
    div_busy <= 1'b1;
    fire(8'h02);
    quiet(20);
    div_busy <= 1'b0;
    instr_holds <= 1'b1;
    quiet(20);
    instr_holds <= 1'b0;
    entry(t);
    chk(32'(ack_source), 32'h1);
    chk(32'(push_data), 32'h80);
    // Trap with the accept flag set, so its clear is really seen
    pulse(3);
    pulse(0);
    entry(t);
    chk(32'(push_data), 32'h80);
    chk(32'(status_word), 32'h00);
    vec(IRQA_TRAP_VEC);
    conclude();
  end
endmodule
